/* design/dftpb_pkg.sv */
// Constants and register map for the drive fine-tuning parameter bank
// Functional notes
// - Country selection picks which default set an initialization loads.
// - Network writes to the country selection register are refused.
// - Scaled monitor equals output frequency times scale, scale 1..999 tenths.
// - Keypad stop key honoured at 0, ignored at 1.
// - Coast-stop cancel restarts from 0Hz at 0, matched speed at 1.
// - Braking limited to percentage of each 100 s interval; 0 disables.
// - Stop command ramps down at 0, coasts at 1.
// - Fan always on, run plus 5 min delay, or temperature controlled.
// - Braking disabled, run only, or always by control mode code.
// - Activation level 330..380 V low class, 660..760 V high class.
// - With code 1, deceleration ramp holds while bus is over threshold.
// - With code 1, carrier lowers automatically as temperature rises.
// - Carrier auto reduce setting is not reachable from the network.
// - Init type 0 clears trips, 1 loads defaults, 2 does both.
package dftpb_pkg;
   localparam logic [15:0] ADDR_INIT_TYPE = 16'h009a;
   localparam logic [15:0] ADDR_COUNTRY = 16'h009b;
   localparam logic [15:0] ADDR_FREQ_SCALE = 16'h009c;
   localparam logic [15:0] ADDR_STOP_KEY = 16'h009d;
   localparam logic [15:0] ADDR_COAST_RESTART = 16'h009e;
   localparam logic [15:0] ADDR_BRAKE_RATIO = 16'h009f;
   localparam logic [15:0] ADDR_STOP_METHOD = 16'h00a0;
   localparam logic [15:0] ADDR_FAN = 16'h00a1;
   localparam logic [15:0] ADDR_BRAKE_MODE = 16'h00a2;
   localparam logic [15:0] ADDR_BRAKE_LEVEL = 16'h00a3;
   localparam logic [15:0] ADDR_OV_HOLD = 16'h00a4;
   localparam logic [15:0] ADDR_OC_SUPPRESS = 16'h00a5;
   localparam logic [15:0] ADDR_CARRIER = 16'h00a6;
   // Ranges
   localparam logic [15:0] SCALE_MIN = 16'h0001;
   localparam logic [15:0] SCALE_MAX = 16'h03e7;
   localparam logic [15:0] RATIO_MAX = 16'h03e8;
   localparam logic [15:0] LVL_LO_MIN = 16'h014a;
   localparam logic [15:0] LVL_LO_MAX = 16'h017c;
   localparam logic [15:0] LVL_HI_MIN = 16'h0294;
   localparam logic [15:0] LVL_HI_MAX = 16'h02f8;
   // Braking window: 100 s, counted in 0.1 % slices of 100 ms
   localparam int CLK_HZ = 40000000;
   localparam int BRAKE_WIN_S = 100;
   localparam int BRAKE_SLICES = 1000;
   localparam int SLICE_CYCLES = CLK_HZ / 10;
   // Fan off delay: 5 min
   localparam int FAN_DELAY_MIN = 5;
   localparam longint FAN_DELAY_CYCLES = 64'(FAN_DELAY_MIN) * 60 * CLK_HZ;
   // Default sets per country (values after initialization)
   localparam logic [15:0] DEF_SCALE = 16'h000a;
   localparam logic [15:0] DEF_RATIO = 16'h0000;
   localparam logic [15:0] DEF_LVL_LO = 16'h0168;
   localparam logic [15:0] DEF_LVL_HI = 16'h02d0;
   localparam logic [15:0] DEF_FAN_C0 = 16'h0000;
   localparam logic [15:0] DEF_FAN_C1 = 16'h0001;
   localparam logic [15:0] DEF_CODE0 = 16'h0000;
   localparam logic [15:0] DEF_COUNTRY = 16'h0000;
endpackage : dftpb_pkg

/* design/dftpb_bank.sv */
// Fine-tuning parameter bank with the drive controls it steers
`timescale 1ns/1ps
module dftpb_bank #(
   parameter int SLICE_CYC = dftpb_pkg::SLICE_CYCLES,
   parameter longint FAN_DELAY_CYC = dftpb_pkg::FAN_DELAY_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Holding-register access from the network slave
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic [15:0] rdata_o,
   output logic ack_o,
   output logic err_o,
   // Local operator side
   input wire logic [15:0] country_set_i,
   input wire logic country_wr_i,
   input wire logic carrier_set_i,
   input wire logic carrier_wr_i,
   input wire logic high_class_i,
   input wire logic init_go_i,
   // Drive status
   input wire logic [15:0] out_freq_i,
   input wire logic [15:0] matched_freq_i,
   input wire logic running_i,
   input wire logic decelerating_i,
   input wire logic stop_cmd_i,
   input wire logic keypad_stop_i,
   input wire logic coast_cancel_i,
   input wire logic bus_over_i,
   input wire logic temp_fan_i,
   input wire logic temp_rising_i,
   input wire logic brake_request_i,
   // Drive controls
   output logic [31:0] scaled_freq_monitor_o,
   output logic stop_o,
   output logic coast_stop_o,
   output logic ramp_down_stop_o,
   output logic restart_o,
   output logic [15:0] restart_freq_o,
   output logic brake_o,
   output logic fan_o,
   output logic ramp_hold_on_overvolt_o,
   output logic oc_suppress_o,
   output logic carrier_reduce_o,
   output logic trip_clear_o,
   output logic [15:0] init_country_o
);

   logic [15:0] init_type_select_reg;
   logic [15:0] init_country_select_reg;
   logic [15:0] freq_display_scale_reg;
   logic keypad_stop_key_disable_reg;
   logic coast_restart_mode_reg;
   logic [15:0] brake_usage_ratio_reg;
   logic stop_method_select_reg;
   logic [1:0] fan_policy_reg;
   logic [1:0] brake_control_mode_reg;
   logic [15:0] brake_activation_level_reg;
   logic overvolt_ramp_hold_enable_reg;
   logic overcurrent_trip_suppress_reg;
   logic carrier_auto_reduce_reg;
   logic [31:0] slice_cnt_reg;
   logic [9:0] slice_idx_reg;
   logic [15:0] used_reg;
   logic [63:0] fan_cnt_reg;
   logic do_param_init;
   logic brake_allowed;
   logic wr_ok;

   // Range check of a write; true when the value may be stored
   function automatic logic dftpb_in_range(input logic [15:0] a,
                                           input logic [15:0] d,
                                           input logic hi);
      case (a)
         dftpb_pkg::ADDR_INIT_TYPE: dftpb_in_range = d <= 16'h0002;
         dftpb_pkg::ADDR_FREQ_SCALE:
            dftpb_in_range = d >= dftpb_pkg::SCALE_MIN &&
                             d <= dftpb_pkg::SCALE_MAX;
         dftpb_pkg::ADDR_STOP_KEY,
         dftpb_pkg::ADDR_COAST_RESTART,
         dftpb_pkg::ADDR_STOP_METHOD,
         dftpb_pkg::ADDR_OV_HOLD,
         dftpb_pkg::ADDR_OC_SUPPRESS: dftpb_in_range = d <= 16'h0001;
         dftpb_pkg::ADDR_BRAKE_RATIO:
            dftpb_in_range = d <= dftpb_pkg::RATIO_MAX;
         dftpb_pkg::ADDR_FAN,
         dftpb_pkg::ADDR_BRAKE_MODE: dftpb_in_range = d <= 16'h0002;
         dftpb_pkg::ADDR_BRAKE_LEVEL:
            dftpb_in_range = hi ?
               (d >= dftpb_pkg::LVL_HI_MIN && d <= dftpb_pkg::LVL_HI_MAX) :
               (d >= dftpb_pkg::LVL_LO_MIN && d <= dftpb_pkg::LVL_LO_MAX);
         default: dftpb_in_range = 1'b0;
      endcase
   endfunction : dftpb_in_range

   // Country and carrier entries are refused from the network
   assign wr_ok = wr_i && dftpb_in_range(addr_i, wdata_i, high_class_i);
   assign do_param_init = init_go_i &&
                          (init_type_select_reg == 16'h0001 ||
                           init_type_select_reg == 16'h0002);

   // Bus answer: one cycle after the strobe
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         rdata_o <= 16'h0000;
      end else begin
         ack_o <= wr_i || rd_i;
         err_o <= (wr_i && !wr_ok) ||
                  (rd_i && (addr_i < dftpb_pkg::ADDR_INIT_TYPE ||
                            addr_i >= dftpb_pkg::ADDR_CARRIER));
         rdata_o <= 16'h0000;
         if (rd_i) begin
            case (addr_i)
               dftpb_pkg::ADDR_INIT_TYPE: rdata_o <= init_type_select_reg;
               dftpb_pkg::ADDR_COUNTRY: rdata_o <= init_country_select_reg;
               dftpb_pkg::ADDR_FREQ_SCALE: rdata_o <= freq_display_scale_reg;
               dftpb_pkg::ADDR_STOP_KEY:
                  rdata_o <= {15'h0000, keypad_stop_key_disable_reg};
               dftpb_pkg::ADDR_COAST_RESTART:
                  rdata_o <= {15'h0000, coast_restart_mode_reg};
               dftpb_pkg::ADDR_BRAKE_RATIO: rdata_o <= brake_usage_ratio_reg;
               dftpb_pkg::ADDR_STOP_METHOD:
                  rdata_o <= {15'h0000, stop_method_select_reg};
               dftpb_pkg::ADDR_FAN: rdata_o <= {14'h0000, fan_policy_reg};
               dftpb_pkg::ADDR_BRAKE_MODE:
                  rdata_o <= {14'h0000, brake_control_mode_reg};
               dftpb_pkg::ADDR_BRAKE_LEVEL:
                  rdata_o <= brake_activation_level_reg;
               dftpb_pkg::ADDR_OV_HOLD:
                  rdata_o <= {15'h0000, overvolt_ramp_hold_enable_reg};
               dftpb_pkg::ADDR_OC_SUPPRESS:
                  rdata_o <= {15'h0000, overcurrent_trip_suppress_reg};
               default: rdata_o <= 16'h0000;
            endcase
         end
      end
   end

   // Locally set entries; only the operator side writes these
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         init_country_select_reg <= dftpb_pkg::DEF_COUNTRY;
         carrier_auto_reduce_reg <= 1'b0;
      end else begin
         if (country_wr_i)
            init_country_select_reg <= country_set_i;
         if (carrier_wr_i)
            carrier_auto_reduce_reg <= carrier_set_i;
      end
   end

   // Network-writable parameters; initialization reloads the chosen set
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         init_type_select_reg <= dftpb_pkg::DEF_CODE0;
         freq_display_scale_reg <= dftpb_pkg::DEF_SCALE;
         keypad_stop_key_disable_reg <= 1'b0;
         coast_restart_mode_reg <= 1'b0;
         brake_usage_ratio_reg <= dftpb_pkg::DEF_RATIO;
         stop_method_select_reg <= 1'b0;
         fan_policy_reg <= 2'h0;
         brake_control_mode_reg <= 2'h0;
         brake_activation_level_reg <= dftpb_pkg::DEF_LVL_LO;
         overvolt_ramp_hold_enable_reg <= 1'b0;
         overcurrent_trip_suppress_reg <= 1'b0;
      end else if (do_param_init) begin
         // Country picks the default set; init type itself is kept
         freq_display_scale_reg <= dftpb_pkg::DEF_SCALE;
         keypad_stop_key_disable_reg <= 1'b0;
         coast_restart_mode_reg <= 1'b0;
         brake_usage_ratio_reg <= dftpb_pkg::DEF_RATIO;
         stop_method_select_reg <= 1'b0;
         fan_policy_reg <= (init_country_select_reg == 16'h0000) ?
                           dftpb_pkg::DEF_FAN_C0[1:0] :
                           dftpb_pkg::DEF_FAN_C1[1:0];
         brake_control_mode_reg <= 2'h0;
         brake_activation_level_reg <= high_class_i ?
            dftpb_pkg::DEF_LVL_HI : dftpb_pkg::DEF_LVL_LO;
         overvolt_ramp_hold_enable_reg <= 1'b0;
         overcurrent_trip_suppress_reg <= 1'b0;
      end else if (wr_ok) begin
         case (addr_i)
            dftpb_pkg::ADDR_INIT_TYPE: init_type_select_reg <= wdata_i;
            dftpb_pkg::ADDR_FREQ_SCALE: freq_display_scale_reg <= wdata_i;
            dftpb_pkg::ADDR_STOP_KEY:
               keypad_stop_key_disable_reg <= wdata_i[0];
            dftpb_pkg::ADDR_COAST_RESTART:
               coast_restart_mode_reg <= wdata_i[0];
            dftpb_pkg::ADDR_BRAKE_RATIO: brake_usage_ratio_reg <= wdata_i;
            dftpb_pkg::ADDR_STOP_METHOD:
               stop_method_select_reg <= wdata_i[0];
            dftpb_pkg::ADDR_FAN: fan_policy_reg <= wdata_i[1:0];
            dftpb_pkg::ADDR_BRAKE_MODE:
               brake_control_mode_reg <= wdata_i[1:0];
            dftpb_pkg::ADDR_BRAKE_LEVEL:
               brake_activation_level_reg <= wdata_i;
            dftpb_pkg::ADDR_OV_HOLD:
               overvolt_ramp_hold_enable_reg <= wdata_i[0];
            dftpb_pkg::ADDR_OC_SUPPRESS:
               overcurrent_trip_suppress_reg <= wdata_i[0];
            default: init_type_select_reg <= init_type_select_reg;
         endcase
      end
   end

   // Stop handling: keypad key may be masked, method picks ramp or coast
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stop_o <= 1'b0;
         coast_stop_o <= 1'b0;
         ramp_down_stop_o <= 1'b0;
         restart_o <= 1'b0;
         restart_freq_o <= 16'h0000;
         trip_clear_o <= 1'b0;
      end else begin
         stop_o <= stop_cmd_i ||
                   (keypad_stop_i && !keypad_stop_key_disable_reg);
         coast_stop_o <= (stop_cmd_i ||
                          (keypad_stop_i && !keypad_stop_key_disable_reg)) &&
                         stop_method_select_reg;
         ramp_down_stop_o <= (stop_cmd_i ||
                              (keypad_stop_i &&
                               !keypad_stop_key_disable_reg)) &&
                             !stop_method_select_reg;
         restart_o <= coast_cancel_i;
         if (coast_cancel_i)
            restart_freq_o <= coast_restart_mode_reg ?
                              matched_freq_i : 16'h0000;
         trip_clear_o <= init_go_i &&
                         (init_type_select_reg == 16'h0000 ||
                          init_type_select_reg == 16'h0002);
      end
   end

   // Monitor and simple enables
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         scaled_freq_monitor_o <= 32'h00000000;
         ramp_hold_on_overvolt_o <= 1'b0;
         oc_suppress_o <= 1'b0;
         carrier_reduce_o <= 1'b0;
         init_country_o <= 16'h0000;
      end else begin
         // Result stays in tenths; caller places the decimal point
         scaled_freq_monitor_o <= out_freq_i * freq_display_scale_reg;
         ramp_hold_on_overvolt_o <= overvolt_ramp_hold_enable_reg &&
                                    decelerating_i && bus_over_i;
         oc_suppress_o <= overcurrent_trip_suppress_reg;
         carrier_reduce_o <= carrier_auto_reduce_reg && temp_rising_i;
         init_country_o <= init_country_select_reg;
      end
   end

   // Braking duty: 1000 slices per window, on-time budget from the ratio
   assign brake_allowed = (brake_control_mode_reg == 2'h2) ||
                          (brake_control_mode_reg == 2'h1 && running_i);
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         slice_cnt_reg <= 32'h00000000;
         slice_idx_reg <= 10'h000;
         used_reg <= 16'h0000;
         brake_o <= 1'b0;
      end else begin
         if (slice_cnt_reg == 32'(SLICE_CYC - 1)) begin
            slice_cnt_reg <= 32'h00000000;
            if (slice_idx_reg == 10'(dftpb_pkg::BRAKE_SLICES - 1)) begin
               slice_idx_reg <= 10'h000;
               used_reg <= 16'h0000; // New 100 s window
            end else begin
               slice_idx_reg <= slice_idx_reg + 10'h001;
               if (brake_o)
                  used_reg <= used_reg + 16'h0001;
            end
         end else begin
            slice_cnt_reg <= slice_cnt_reg + 32'h00000001;
         end
         brake_o <= brake_request_i && brake_allowed &&
                    brake_usage_ratio_reg != 16'h0000 &&
                    used_reg < brake_usage_ratio_reg;
      end
   end

   // Fan policy; mode 1 holds on for the off delay after running
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fan_cnt_reg <= 64'h0000000000000000;
         fan_o <= 1'b1;
      end else begin
         if (running_i)
            fan_cnt_reg <= 64'h0000000000000000;
         else if (fan_cnt_reg < 64'(FAN_DELAY_CYC))
            fan_cnt_reg <= fan_cnt_reg + 64'h0000000000000001;
         case (fan_policy_reg)
            2'h0: fan_o <= 1'b1;
            2'h1: fan_o <= running_i ||
                           fan_cnt_reg < 64'(FAN_DELAY_CYC);
            2'h2: fan_o <= temp_fan_i;
            default: fan_o <= 1'b1;
         endcase
      end
   end

endmodule : dftpb_bank

/* dv/dftpb_checker.sv */
// Port checker for the fine-tuning parameter bank
`timescale 1ns/1ps
module dftpb_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic high_class_i,
   input wire logic [15:0] rdata_o,
   input wire logic ack_o,
   input wire logic err_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   // Every taken request answers exactly one cycle later
   property p_ack;
      (wr_i || rd_i) |=> ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   // Quiet bus keeps the answer lines at rest
   property p_idle;
      !(wr_i || rd_i) |=> !ack_o && !err_o && rdata_o == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_country;
      wr_i && addr_i == dftpb_pkg::ADDR_COUNTRY |=> err_o;
   endproperty
   a_country: assert property (p_country) else $error("write taken");
   property p_carrier;
      (wr_i || rd_i) && addr_i == dftpb_pkg::ADDR_CARRIER
         |=> err_o && rdata_o == 16'h0000;
   endproperty
   a_carrier: assert property (p_carrier) else $error("exposed");
   property p_scale;
      wr_i && addr_i == dftpb_pkg::ADDR_FREQ_SCALE &&
         (wdata_i < 16'h0001 || wdata_i > 16'h03e7) |=> err_o;
   endproperty
   a_scale: assert property (p_scale) else $error("scale taken");
   property p_ratio;
      wr_i && addr_i == dftpb_pkg::ADDR_BRAKE_RATIO && wdata_i > 16'h03e8
         |=> err_o;
   endproperty
   a_ratio: assert property (p_ratio) else $error("ratio taken");
   // Legal window follows the voltage class
   property p_level;
      wr_i && addr_i == dftpb_pkg::ADDR_BRAKE_LEVEL && (high_class_i ?
         (wdata_i < 16'h0294 || wdata_i > 16'h02f8) :
         (wdata_i < 16'h014a || wdata_i > 16'h017c)) |=> err_o;
   endproperty
   a_level: assert property (p_level) else $error("level taken");
   property p_code3;
      wr_i && (addr_i == dftpb_pkg::ADDR_FAN ||
         addr_i == dftpb_pkg::ADDR_BRAKE_MODE) && wdata_i > 16'h0002
         |=> err_o;
   endproperty
   a_code3: assert property (p_code3) else $error("code taken");
   property p_rd_ok;
      rd_i && addr_i >= 16'h009a && addr_i <= 16'h00a5 |=> !err_o;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("read refused");
endmodule : dftpb_checker

bind dftpb_bank dftpb_checker dftpb_checker_i (.clk_i(clk_i),
   .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .high_class_i(high_class_i), .rdata_o(rdata_o),
   .ack_o(ack_o), .err_o(err_o));

/* dv/dftpb_net_master.sv */
// Network master model issuing holding-register requests
`timescale 1ns/1ps
module dftpb_net_master (
   input wire logic clk_i,
   output logic wr_o,
   output logic rd_o,
   output logic [15:0] addr_o,
   output logic [15:0] wdata_o,
   input wire logic [15:0] rdata_i,
   input wire logic ack_i,
   input wire logic err_i
);
   // Idle bus at time zero
   initial begin
      {wr_o, rd_o, addr_o, wdata_o} = '0;
   end
   // One-cycle request, then a bounded wait for the answer
   task automatic xfer(input logic w, input logic [15:0] a,
         input logic [15:0] d, output logic [15:0] q, output logic e);
      int n;
      @(posedge clk_i);
      {wr_o, rd_o, addr_o, wdata_o} <= {w, !w, a, d};
      @(posedge clk_i);
      {wr_o, rd_o} <= 2'b00;
      // Released lines must not keep showing the last value
      {addr_o, wdata_o} <= {~a, ~d};
      #1;
      n = 0;
      while (!ack_i && n < 4) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      q = ack_i ? rdata_i : 16'hxxxx; // Missing answer never matches
      e = ack_i ? err_i : 1'bx;
   endtask : xfer
endmodule : dftpb_net_master

/* dv/tb.sv */
// Self-checking bench for the fine-tuning parameter bank
`timescale 1ns/1ps
module tb;
   logic clk_i, rst_n_i, wr_i, rd_i, ack_o, err_o, country_wr_i, f;
   logic carrier_set_i, carrier_wr_i, high_class_i, init_go_i, running_i;
   logic decelerating_i, stop_cmd_i, keypad_stop_i, coast_cancel_i;
   logic bus_over_i, temp_fan_i, temp_rising_i, brake_request_i, stop_o;
   logic coast_stop_o, ramp_down_stop_o, restart_o, brake_o, fan_o;
   logic ramp_hold_on_overvolt_o, oc_suppress_o, carrier_reduce_o;
   logic trip_clear_o;
   // Latches start clear here so only the latch process drives them
   logic trip_seen = 1'b0;
   logic rst_seen = 1'b0;
   logic [15:0] addr_i, wdata_i, rdata_o, country_set_i, out_freq_i, q, v;
   logic [15:0] matched_freq_i, restart_freq_o, init_country_o;
   logic [31:0] scaled_freq_monitor_o;
   logic [35:0] e;
   int num_errors = 0;
   int compares = 0;
   // Address, value, refused flag; each group opens with a good write
   localparam logic [35:0] EDGES [26] = '{
      36'h009c_0001_0, 36'h009c_0000_1, 36'h009c_03e7_0,
      36'h009c_03e8_1, 36'h009f_03e8_0, 36'h009f_03e9_1,
      36'h00a3_014a_0, 36'h00a3_0149_1, 36'h00a3_017c_0,
      36'h00a3_017d_1, 36'h00a1_0002_0, 36'h00a1_0003_1,
      36'h00a2_0002_0, 36'h00a2_0003_1, 36'h009d_0001_0,
      36'h009d_0002_1, 36'h009e_0001_0, 36'h009e_0002_1,
      36'h00a0_0001_0, 36'h00a0_0002_1, 36'h00a4_0001_0,
      36'h00a4_0002_1, 36'h00a5_0001_0, 36'h00a5_0002_1,
      36'h009a_0002_0, 36'h009a_0003_1};
   // Short counts so the braking slices and fan delay fit the run
   dftpb_bank #(.SLICE_CYC(4), .FAN_DELAY_CYC(64'd20)) dftpb_bank_i (
      .clk_i, .rst_n_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .ack_o,
      .err_o, .country_set_i, .country_wr_i, .carrier_set_i, .carrier_wr_i,
      .high_class_i, .init_go_i, .out_freq_i, .matched_freq_i, .running_i,
      .decelerating_i, .stop_cmd_i, .keypad_stop_i, .coast_cancel_i,
      .bus_over_i, .temp_fan_i, .temp_rising_i, .brake_request_i,
      .scaled_freq_monitor_o, .stop_o, .coast_stop_o, .ramp_down_stop_o,
      .restart_o, .restart_freq_o, .brake_o, .fan_o, .ramp_hold_on_overvolt_o,
      .oc_suppress_o, .carrier_reduce_o, .trip_clear_o, .init_country_o);
   dftpb_net_master dftpb_net_master_i (.clk_i, .wr_o(wr_i), .rd_o(rd_i),
      .addr_o(addr_i), .wdata_o(wdata_i), .rdata_i(rdata_o), .ack_i(ack_o),
      .err_i(err_o));
   // Clock, idle inputs and reset low at time zero
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      {country_wr_i, carrier_set_i, carrier_wr_i, high_class_i, init_go_i,
         running_i, decelerating_i, stop_cmd_i, keypad_stop_i, coast_cancel_i,
         bus_over_i, temp_fan_i, temp_rising_i, brake_request_i,
         rst_n_i, country_set_i, out_freq_i, matched_freq_i} = '0;
   end
   // Pulses last one cycle, so latch them for later checks
   always @(posedge clk_i) begin
      if (trip_clear_o) trip_seen <= 1'b1;
      if (restart_o) rst_seen <= 1'b1;
   end
   task automatic close_out;
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic x);
      dftpb_net_master_i.xfer(1'b1, a, d, q, f);
      chk1(f, x);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] d, input logic x);
      dftpb_net_master_i.xfer(1'b0, a, 16'h0000, q, f);
      chk({15'h0, f, q}, {15'h0, x, d});
   endtask : rd
   task automatic settle;
      repeat (3) @(posedge clk_i);
   endtask : settle
   // Hang guard, well past the expected run of about 230 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(16'h009c, 16'h000a, 1'b0);
      rd(16'h00a3, 16'h0168, 1'b0);
      wr(16'h009b, 16'h0001, 1'b1);
      rd(16'h009b, 16'h0000, 1'b0);
      wr(16'h00a6, 16'h0001, 1'b1);
      rd(16'h00a6, 16'h0000, 1'b1);
      rd(16'h00a7, 16'h0000, 1'b1);
      foreach (EDGES[i]) begin
         e = EDGES[i];
         if (!e[0]) v = e[19:4];
         wr(e[35:20], e[19:4], e[0]);
         rd(e[35:20], v, 1'b0);
      end
      @(posedge clk_i) {high_class_i, out_freq_i} <= {1'b1, 16'h1234};
      wr(16'h00a3, 16'h0294, 1'b0);
      wr(16'h00a3, 16'h02f9, 1'b1);
      wr(16'h00a3, 16'h017c, 1'b1);
      chk(scaled_freq_monitor_o, 32'h1234 * 32'd999);
      // Stop key ignored at 1, then honoured at 0
      @(posedge clk_i) keypad_stop_i <= 1'b1;
      settle();
      chk1(stop_o, 1'b0);
      wr(16'h009d, 16'h0000, 1'b0);
      settle();
      chk1(stop_o, 1'b1);
      @(posedge clk_i) {keypad_stop_i, stop_cmd_i} <= 2'b01;
      settle();
      chk({coast_stop_o, ramp_down_stop_o}, 2'b10);
      wr(16'h00a0, 16'h0000, 1'b0);
      settle();
      chk({coast_stop_o, ramp_down_stop_o}, 2'b01);
      @(posedge clk_i) {stop_cmd_i, matched_freq_i} <= {1'b0, 16'h0123};
      @(posedge clk_i) coast_cancel_i <= 1'b1;
      @(posedge clk_i) coast_cancel_i <= 1'b0;
      settle();
      chk({rst_seen, restart_freq_o}, 17'h10123);
      wr(16'h009e, 16'h0000, 1'b0);
      @(posedge clk_i) coast_cancel_i <= 1'b1;
      @(posedge clk_i) {coast_cancel_i, decelerating_i, bus_over_i} <= 3'b011;
      settle();
      chk(restart_freq_o, 16'h0000);
      chk1(ramp_hold_on_overvolt_o, 1'b1);
      chk1(oc_suppress_o, 1'b1);
      @(posedge clk_i) {bus_over_i, brake_request_i} <= 2'b01;
      settle();
      chk1(ramp_hold_on_overvolt_o, 1'b0);
      chk1(brake_o, 1'b1);
      wr(16'h00a2, 16'h0001, 1'b0);
      settle();
      chk1(brake_o, 1'b0);
      @(posedge clk_i) running_i <= 1'b1;
      settle();
      chk1(brake_o, 1'b1);
      wr(16'h009f, 16'h0000, 1'b0);
      settle();
      chk1(brake_o, 1'b0);
      chk1(fan_o, 1'b0);
      wr(16'h00a1, 16'h0001, 1'b0);
      @(posedge clk_i) running_i <= 1'b0;
      settle();
      chk1(fan_o, 1'b1);
      repeat (30) @(posedge clk_i);
      chk1(fan_o, 1'b0);
      @(posedge clk_i) {carrier_set_i, carrier_wr_i, temp_rising_i} <= 3'b111;
      // Country 1 written locally, carrier strobe dropped in the same cycle
      @(posedge clk_i) {country_set_i, country_wr_i, carrier_wr_i} <= 18'h00006;
      @(posedge clk_i) country_wr_i <= 1'b0;
      wr(16'h00a1, 16'h0000, 1'b0);
      chk1(carrier_reduce_o, 1'b1);
      // Type 2 clears trips and loads the country's defaults
      @(posedge clk_i) init_go_i <= 1'b1;
      @(posedge clk_i) init_go_i <= 1'b0;
      settle();
      chk({trip_seen, init_country_o}, 17'h10001);
      rd(16'h00a1, 16'h0001, 1'b0);
      rd(16'h009c, 16'h000a, 1'b0);
      close_out();
   end
endmodule : tb
